// ===== gst_pkg.sv
// Package for the gated sixteen bit timer: field layouts, reset values,
// clock source codes and prescale codes.
// Assumes a single 125 MHz system clock domain.
package gst_pkg;

  // Clock source selection
  typedef enum logic [1:0] {
    GST_SRC_INSTR = 2'h0, // Instruction clock, one tick every four cycles
    GST_SRC_FOSC = 2'h1,  // Full-rate oscillator, four counts per instr
    GST_SRC_EXT = 2'h2,   // External clock input pin
    GST_SRC_RSVD = 2'h3   // Reserved, no ticks
  } gst_src_t;

  // Field widths and positions
  localparam int GST_CNT_W = 16;
  localparam int GST_BYTE_W = 8;
  localparam int GST_PRE_W = 3;
  localparam int GST_HI_LSB = 8;

  // Reset values
  localparam logic [15:0] GST_CNT_RST = 16'h0000;
  localparam logic [7:0] GST_BUF_RST = 8'h00;
  localparam logic [2:0] GST_PRE_RST = 3'h0;
  localparam logic [15:0] GST_CNT_MAX = 16'hffff;

  // Instruction cycle: four system clocks
  localparam int GST_INSTR_DIV = 4;
  localparam logic [1:0] GST_PHASE_LAST = 2'h3;
  // Counts added per prescaled tick
  localparam logic [15:0] GST_FOSC_STEP = 16'h0001;

  // Prescale divider terminal value for a select code (divide 1/2/4/8)
  function automatic logic [2:0] gst_pre_last(input logic [1:0] sel);
    case (sel)
      2'h0: gst_pre_last = 3'h0;
      2'h1: gst_pre_last = 3'h1;
      2'h2: gst_pre_last = 3'h3;
      default: gst_pre_last = 3'h7;
    endcase
  endfunction

endpackage

// ===== gst_edge_detect.sv
// Edge detector for the external clock input.
// Assumes the input is either already synchronised or a same-domain level.
// Arms on a falling edge; reports rising edges only once armed.
module gst_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic disarm,
  // Sampled level
  input wire logic level,
  // Rising edge seen while armed
  output logic rise
);

  logic prevFf;
  logic armedFf;

  // Previous level for edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevFf <= 1'b0;
    end else begin
      prevFf <= level;
    end
  end

  // Arm on falling edge, disarm on request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      armedFf <= 1'b0;
    end else if (disarm) begin
      armedFf <= 1'b0;
    end else if (prevFf && !level) begin
      armedFf <= 1'b1;
    end
  end

  assign rise = armedFf && !disarm && !prevFf && level;

endmodule

// ===== gst_timer.sv
// Gated sixteen bit timer/counter core with byte access ports.
// Assumes byte strobes come from logic on clk; ext clock and gate are pins.
module gst_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic onBit,
  input wire logic gate_enable_bit,
  input wire logic gate_polarity_bit,
  input wire logic [1:0] clockSource,
  input wire logic [1:0] prescale_select,
  input wire logic syncBypass,
  input wire logic wide_access_enable,
  input wire logic sleepMode,
  // Pins
  input wire logic ext_clock_input,
  input wire logic gate_signal,
  // Byte access
  input wire logic lowWrite,
  input wire logic highWrite,
  input wire logic [7:0] writeData,
  input wire logic lowRead,
  input wire logic highRead,
  input wire logic overflowClear,
  // Status
  output logic [7:0] count_low_byte,
  output logic [7:0] count_high_byte,
  output logic [15:0] timer_count,
  output logic overflow_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic rstSync1Ff, rstSync2Ff, rstnInt;
  logic extS1Ff, extS2Ff, gateS1Ff, gateS2Ff, extRawFf, extRaw2Ff;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1Ff <= 1'b0;
      rstSync2Ff <= 1'b0;
    end else begin
      rstSync1Ff <= 1'b1;
      rstSync2Ff <= rstSync1Ff;
    end
  end
  assign rstnInt = rstSync2Ff;

  // Two-stage synchronisers; held while asleep
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      extS1Ff <= 1'b0;
      extS2Ff <= 1'b0;
      gateS1Ff <= 1'b0;
      gateS2Ff <= 1'b0;
    end else if (!sleepMode) begin
      extS1Ff <= ext_clock_input;
      extS2Ff <= extS1Ff;
      gateS1Ff <= gate_signal;
      gateS2Ff <= gateS1Ff;
    end
  end

  // Bypass path: two capture stages that are never frozen, so they run
  // in sleep; only the second stage is read by the edge logic
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      extRawFf <= 1'b0;
      extRaw2Ff <= 1'b0;
    end else begin
      extRawFf <= ext_clock_input;
      extRaw2Ff <= extRawFf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable and clock source selection

  logic gateMatch, countEnable, extLevel, extRise, disarm;
  logic [1:0] phaseFf;
  logic srcTick;
  gst_pkg::gst_src_t src;

  assign src = gst_pkg::gst_src_t'(clockSource);
  assign gateMatch = (gateS2Ff == gate_polarity_bit);
  // On bit gates all, gate enable selects gated mode
  assign countEnable = onBit && (!gate_enable_bit || gateMatch);

  // Bypass selects raw capture; sleep without bypass freezes the sync path
  assign extLevel = syncBypass ? extRaw2Ff : extS2Ff;
  assign disarm = !onBit || lowWrite || highWrite;

  gst_edge_detect uEdge (
    .clk(clk),
    .rstn(rstnInt),
    .disarm(disarm),
    .level(extLevel),
    .rise(extRise)
  );

  // Instruction phase counter, stopped in sleep
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      phaseFf <= 2'h0;
    end else if (!sleepMode) begin
      phaseFf <= phaseFf + 2'h1;
    end
  end

  // Raw tick from the chosen source
  always_comb begin
    case (src)
      gst_pkg::GST_SRC_INSTR:
        srcTick = !sleepMode && (phaseFf == gst_pkg::GST_PHASE_LAST);
      gst_pkg::GST_SRC_FOSC: srcTick = !sleepMode;
      gst_pkg::GST_SRC_EXT:
        srcTick = extRise && (syncBypass || !sleepMode);
      default: srcTick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler

  logic [2:0] preFf;
  logic preTick;

  assign preTick = countEnable && srcTick &&
                   (preFf == gst_pkg::gst_pre_last(prescale_select));

  // Hidden prescale counter, cleared by low byte write only
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      preFf <= gst_pkg::GST_PRE_RST;
    end else if (lowWrite) begin
      preFf <= gst_pkg::GST_PRE_RST;
    end else if (countEnable && srcTick) begin
      if (preFf >= gst_pkg::gst_pre_last(prescale_select)) begin
        preFf <= gst_pkg::GST_PRE_RST;
      end else begin
        preFf <= preFf + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, buffer and overflow

  logic [15:0] cntFf, nxt_cnt;
  logic [7:0] hiBufFf;
  logic wrap, incTaken;

  // Increment actually taken: a write to the live counter discards it
  assign incTaken = preTick && !lowWrite &&
                    !(highWrite && !wide_access_enable);
  assign wrap = incTaken && (cntFf == gst_pkg::GST_CNT_MAX);

  // Next counter value: writes beat increments
  always_comb begin
    nxt_cnt = cntFf;
    if (lowWrite) begin
      if (wide_access_enable) begin
        nxt_cnt = {hiBufFf, writeData};
      end else begin
        nxt_cnt = {cntFf[15:8], writeData};
      end
    end else if (highWrite && !wide_access_enable) begin
      nxt_cnt = {writeData, cntFf[7:0]};
    end else if (preTick) begin
      nxt_cnt = cntFf + gst_pkg::GST_FOSC_STEP;
    end
  end

  // Counter register
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      cntFf <= gst_pkg::GST_CNT_RST;
    end else begin
      cntFf <= nxt_cnt;
    end
  end

  // High byte buffer: loaded by wide-mode high writes and low reads
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      hiBufFf <= gst_pkg::GST_BUF_RST;
    end else if (wide_access_enable && highWrite) begin
      hiBufFf <= writeData;
    end else if (wide_access_enable && lowRead) begin
      hiBufFf <= cntFf[15:8];
    end
  end

  // Sticky overflow flag; set wins over clear
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (overflowClear) begin
      overflow_flag <= 1'b0;
    end
  end

  // Registered read views; counter is clocked so bytes are stable
  always_ff @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      count_low_byte <= 8'h00;
      count_high_byte <= 8'h00;
      timer_count <= 16'h0000;
    end else begin
      count_low_byte <= nxt_cnt[7:0];
      timer_count <= nxt_cnt;
      if (wide_access_enable) begin
        count_high_byte <= (lowRead && !highWrite) ? cntFf[15:8] :
                           (highWrite ? writeData : hiBufFf);
      end else begin
        count_high_byte <= nxt_cnt[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Wide write pair: high byte into buffer, then low byte loads both
  sequence s_wide_pair;
    (wide_access_enable && highWrite && !lowWrite) ##1
    (wide_access_enable && lowWrite && !highWrite);
  endsequence

  a_write_wins: assert property (@(posedge clk) disable iff (!rstnInt)
    (lowWrite && !wide_access_enable) |=> cntFf[7:0] == $past(writeData))
    else $error("Low write did not load counter");
  a_off_holds: assert property (@(posedge clk) disable iff (!rstnInt)
    (!onBit && !lowWrite && !highWrite) |=> cntFf == $past(cntFf))
    else $error("Counter moved while off");
  a_gate_holds: assert property (@(posedge clk) disable iff (!rstnInt)
    (gate_enable_bit && !gateMatch && !lowWrite && !highWrite)
    |=> cntFf == $past(cntFf))
    else $error("Counter moved with gate inactive");
  a_pre_clear: assert property (@(posedge clk) disable iff (!rstnInt)
    lowWrite |=> preFf == 3'h0)
    else $error("Prescaler not cleared by low write");
  a_wrap_zero: assert property (@(posedge clk) disable iff (!rstnInt)
    wrap |=> (cntFf == 16'h0000) && overflow_flag)
    else $error("Wrap did not give zero and flag");
  a_flag_set: assert property (@(posedge clk) disable iff (!rstnInt)
    (wrap && overflowClear) |=> overflow_flag)
    else $error("Clear beat a coinciding overflow");
  a_wide_pair: assert property (@(posedge clk) disable iff (!rstnInt)
    s_wide_pair |=> cntFf == {$past(writeData, 2), $past(writeData)})
    else $error("Wide write pair did not load both bytes");
  a_wide_load: assert property (@(posedge clk) disable iff (!rstnInt)
    (wide_access_enable && lowWrite)
    |=> cntFf == {$past(hiBufFf), $past(writeData)})
    else $error("Wide low write did not load both bytes");
  a_buf_latch: assert property (@(posedge clk) disable iff (!rstnInt)
    (wide_access_enable && lowRead && !highWrite)
    |=> hiBufFf == $past(cntFf[15:8]))
    else $error("Low read did not latch high byte");
  a_wide_hiwr: assert property (@(posedge clk) disable iff (!rstnInt)
    (wide_access_enable && highWrite && !lowWrite)
    |=> cntFf[15:8] == $past(cntFf[15:8]) || $past(preTick))
    else $error("Wide high write reached counter");
  a_pre_range: assert property (@(posedge clk) disable iff (!rstnInt)
    (prescale_select == 2'h1 && preFf <= 3'h1) |=> preFf <= 3'h1)
    else $error("Prescaler beyond divide by two");
  a_hiwr_pre: assert property (@(posedge clk) disable iff (!rstnInt)
    (highWrite && !lowWrite && !(countEnable && srcTick))
    |=> preFf == $past(preFf))
    else $error("High write disturbed the prescaler");
  a_rise_armed: assert property (@(posedge clk) disable iff (!rstnInt)
    disarm |=> !extRise)
    else $error("Rising edge counted before rearming");
  a_sync_sleep: assert property (@(posedge clk) disable iff (!rstnInt)
    sleepMode |=> (extS2Ff == $past(extS2Ff)) &&
    (gateS2Ff == $past(gateS2Ff)))
    else $error("Synchroniser moved during sleep");

endmodule

// ===== gst_pin_src.sv
// Far-side pin model for the timer: external clock and gate sources.
// Assumes the bench calls its tasks just after rising edges of clk.
module gst_pin_src (
  // Clock
  input wire logic clk,
  // Pins driven toward the timer
  output logic extClk,
  output logic gateLvl
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Idle levels: the clock pin stands still outside pulse trains
  initial begin
    extClk = 1'b0;
    gateLvl = 1'b0; // Plain pin level, never a comparator output
  end

  // Single level change, launched just after an edge
  task automatic setClk(input logic v);
    @(posedge clk);
    #1;
    extClk = v;
  endtask

  // Gate level, held until changed
  task automatic setGate(input logic v);
    gateLvl = v;
  endtask

  // Full pulses, falling then rising, long enough for the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge clk);
      #1;
      extClk = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      extClk = 1'b1;
    end
  endtask
endmodule

// ===== gated_sixteen_bit_timer_tb.sv
// Self-checking bench for the gated sixteen bit timer core.
// Assumes one 125 MHz clock; pins come from the far-side pin model.
module gated_sixteen_bit_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int sel; logic [15:0] lo; logic [15:0] hi;} gst_note_t;
  logic clk, rstn, onBit, gateEn, gatePol, syncBypass, wideEn, sleepMode;
  logic [1:0] clockSource, preSel;
  logic [7:0] wrData, lowByte, highByte;
  logic lowWrite, highWrite, lowRead, highRead, ovfClear, ovfFlag;
  logic extClk, gateLvl;
  logic [15:0] timerCount, seen, d;
  int miscompares, check_count;
  gst_note_t notes[$];
  gst_note_t cur;
  string nm[5] = '{"timer_count", "count_low_byte", "count_high_byte",
                   "overflow_flag", "timer_count_low"};

  ////////////////////////////////////////////////////////////////////////////
  // Design, pin model and clock
  gst_timer u_gst_timer (.clk(clk), .rstn(rstn), .onBit(onBit),
    .gate_enable_bit(gateEn), .gate_polarity_bit(gatePol),
    .clockSource(clockSource), .prescale_select(preSel),
    .syncBypass(syncBypass), .wide_access_enable(wideEn),
    .sleepMode(sleepMode), .ext_clock_input(extClk),
    .gate_signal(gateLvl), .lowWrite(lowWrite), .highWrite(highWrite),
    .writeData(wrData), .lowRead(lowRead), .highRead(highRead),
    .overflowClear(ovfClear), .count_low_byte(lowByte),
    .count_high_byte(highByte), .timer_count(timerCount),
    .overflow_flag(ovfFlag));
  gst_pin_src u_gst_pin_src (.clk(clk), .extClk(extClk), .gateLvl(gateLvl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, notes and verdict
  task check(string n, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task note(int sel, logic [15:0] lo, logic [15:0] hi);
    notes.push_back('{sel, lo, hi});
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watcher: outputs are settled at the falling edge
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      case (cur.sel)
        0: seen = timerCount;
        1: seen = {8'h00, lowByte};
        2: seen = {8'h00, highByte};
        3: seen = {15'h0000, ovfFlag};
        default: seen = {8'h00, timerCount[7:0]};
      endcase
      if (cur.lo === cur.hi) check(nm[cur.sel], seen, cur.lo);
      else check(nm[cur.sel], {15'h0000, seen >= cur.lo && seen <= cur.hi},
                 16'h0001);
    end
  end
  // Hang guard, well beyond the thousand or so cycles the tests need
  initial begin
    #(20000 * 8);
    miscompares++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drivers
  task step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle strobe: 0 low write, 1 high write, 2 low read, 3 clear, 4 high read
  task strobe(int k, logic [7:0] v);
    step();
    wrData = v;
    lowWrite = (k == 0);
    highWrite = (k == 1);
    lowRead = (k == 2);
    ovfClear = (k == 3);
    highRead = (k == 4);
    step();
    {lowWrite, highWrite, lowRead, ovfClear, highRead} = 5'h00;
  endtask
  // Load zero while stopped, then run for n cycles and stop
  task run(logic [1:0] src, logic [1:0] sel, int n);
    onBit = 1'b0;
    clockSource = src;
    preSel = sel;
    strobe(1, 8'h00);
    strobe(0, 8'h00);
    onBit = 1'b1;
    step(n);
    onBit = 1'b0;
    step(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rstn, onBit, gateEn, gatePol, syncBypass, sleepMode} = 6'h00;
    {lowWrite, highWrite, lowRead, ovfClear, highRead} = 5'h00;
    wideEn = 1'b1;
    wrData = 8'h00;
    preSel = 2'h0;
    clockSource = gst_pkg::GST_SRC_FOSC;
    void'($urandom(32'hab868ec5));
    d = 16'($urandom);
    step(4);
    rstn = 1'b1;
    step(3);
    note(0, 16'h0000, 16'h0000);
    note(3, 16'h0000, 16'h0000);
    strobe(1, 8'hab);
    note(0, 16'h0000, 16'h0000);
    strobe(0, 8'hcd);
    note(0, 16'habcd, 16'habcd);
    strobe(2, 8'h00);
    strobe(1, 8'h55);
    note(2, 16'h0055, 16'h0055);
    note(0, 16'habcd, 16'habcd);
    strobe(2, 8'h00);
    note(2, 16'h00ab, 16'h00ab);
    strobe(4, 8'h00);
    note(2, 16'h00ab, 16'h00ab);
    wideEn = 1'b0;
    strobe(1, d[15:8]);
    strobe(0, d[7:0]);
    note(0, d, d);
    note(1, {8'h00, d[7:0]}, {8'h00, d[7:0]});
    note(2, {8'h00, d[15:8]}, {8'h00, d[15:8]});
    wideEn = 1'b1;
    step(20);
    note(0, d, d);
    for (int s = 0; s < 4; s++) begin
      run(gst_pkg::GST_SRC_FOSC, 2'(s), 96);
      note(0, 16'((96 >> s) - 1), 16'((96 >> s) + 1));
    end
    run(gst_pkg::GST_SRC_INSTR, 2'h0, 96);
    note(0, 16'd23, 16'd25);
    run(gst_pkg::GST_SRC_RSVD, 2'h0, 32);
    note(0, 16'h0000, 16'h0000);
    gateEn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      gatePol = i[0];
      u_gst_pin_src.setGate(i[1]);
      run(gst_pkg::GST_SRC_FOSC, 2'h0, 32);
      note(0, (i[0] == i[1]) ? 16'd31 : 16'd0,
           (i[0] == i[1]) ? 16'd33 : 16'd0);
    end
    gateEn = 1'b0;
    strobe(1, 8'hff);
    strobe(0, 8'hfd);
    onBit = 1'b1;
    step(8);
    onBit = 1'b0;
    step(2);
    note(3, 16'h0001, 16'h0001);
    note(0, 16'h0002, 16'h0007);
    strobe(3, 8'h00);
    note(3, 16'h0000, 16'h0000);
    onBit = 1'b1;
    step(5);
    strobe(0, d[7:0]);
    note(4, {8'h00, d[7:0]}, {8'h00, d[7:0]});
    onBit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      clockSource = gst_pkg::GST_SRC_EXT;
      syncBypass = (i == 1);
      sleepMode = (i > 0);
      u_gst_pin_src.setClk(1'b0);
      strobe(1, d[15:8]); // Timer stopped before writing
      strobe(0, d[7:0]);
      onBit = 1'b1;
      u_gst_pin_src.setClk(1'b1);
      u_gst_pin_src.pulses(5);
      step(6);
      onBit = 1'b0;
      step(2);
      note(0, d + ((i == 2) ? 16'h0 : 16'h5),
           d + ((i == 2) ? 16'h0 : 16'h5));
    end
    sleepMode = 1'b0;
    step(2);
    print_verdict();
  end
endmodule
